// ===== rtl/slq_pkg.sv
// Package for the status lamp sequencer: register map, lamp codes, timing constants.
package slq_pkg;

	// Lamp drive: one bit per colour, both lit never occurs
	typedef struct packed {
		logic red;
		logic green;
	} slq_lamp_type;

	// Protocol selection codes
	localparam logic [1:0] PROTO_ETHIP = 2'h0;
	localparam logic [1:0] PROTO_MODBUS = 2'h1;
	localparam logic [1:0] PROTO_PNET = 2'h2;

	// Condition inputs gathered from drive, adapter and encoder
	typedef struct packed {
		logic self_test;
		logic link_wait;
		logic drive_ok;
		logic net_ok;
		logic name_or_ip_set;
		logic flash_ok;
		logic flash_fail;
		logic cfg_changed;
		logic proc_link_fail;
		logic encoder_err;
		logic over_temp;
		logic eth_link;
		logic cip_open;
		logic dup_ip;
		logic name_mismatch;
		logic ioc_conn;
		logic ioc_run;
		logic [2:0] tcp_count;
	} slq_cond_type;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_INT_STATUS = 8'h08;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h0c;
	localparam logic [7:0] OFS_INT_CLEAR = 8'h10;

	// Reset values
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [3:0] INT_ENABLE_RESET = 4'h0;

	// Interrupt and status bit positions
	localparam int INT_PROC_LINK = 0;
	localparam int INT_OVER_TEMP = 1;
	localparam int INT_FLASH_FAIL = 2;
	localparam int INT_CFG_CHANGED = 3;
	localparam int STATUS_FLASH_OK = 4;

	// Timing
	localparam int CLK_HZ = 40000000;
	localparam int HALF_PERIOD_MS = 500;
	localparam int HALF_PERIOD_CYCLES = CLK_HZ / 1000 * HALF_PERIOD_MS;
	localparam int GROUP_PAUSE_MS = 2000;
	localparam int GROUP_PAUSE_HALVES = GROUP_PAUSE_MS / HALF_PERIOD_MS;
	localparam int ENC_BLINKS = 3;
	localparam int MAX_TCP_BLINKS = 5;

endpackage

// ===== rtl/slq_status_lamp_sequencer.sv
// Status lamp sequencer: drives module and network health lamps, with APB status and interrupts.
`timescale 1ns/1ps

// Summary of operation
// - Processor link fault latches alternating red/green module lamp until power cycle.
// - Waiting for a valid network link flashes module lamp green.
// - Successful flash write shows green and refuses commands until power cycle.
// - Protocols one and two: steady green module lamp when drive and network run.
// - Protocol three: steady green module lamp once name or IP assigned.
// - Flash red module lamp on config change, else on latched flash failure.
// - Over-temperature latches steady red module lamp until power removal.
// - Power-up initialisation blinks module lamp green.
// - Encoder error at power-up blinks module lamp red exactly three times.
// - Protocol one: network lamp flashes green with link but no CIP connection.
// - Protocol two: network lamp blinks TCP count, up to five, two second pause.
// - Protocol three: network lamp flashes green when controller stopped.
// - Protocol three: network lamp steady green when controller running.
// - Protocol three: network lamp off on duplicate IP, name mismatch, no controller.
// - Protocol one, module flashing red: network lamp flashes red on config change.
// - Protocols one and two: network lamp steady red on duplicate IP.
module slq_status_lamp_sequencer
	import slq_pkg::*;
#(
	parameter int HALF_CYCLES = HALF_PERIOD_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire slq_cond_type cond,
	output slq_lamp_type module_health_lamp,
	output slq_lamp_type network_health_lamp,
	output logic cmd_refused,
	output logic irq
);

	// ==================================================
	// Elaboration checks
	// The blink-code step counter is four bits wide, so a group must fit in fifteen halves
	if (HALF_CYCLES < 2)
		$error("HALF_CYCLES must be at least 2");
	if (2 * MAX_TCP_BLINKS + GROUP_PAUSE_HALVES > 15)
		$error("Blink group does not fit the step counter");

	// ==================================================
	// Input synchroniser: conditions come from other logic on unknown timing
	slq_cond_type cond_meta;
	slq_cond_type cond_s;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cond_meta <= '0;
			cond_s <= '0;
		end
		else
		begin
			cond_meta <= cond;
			cond_s <= cond_meta;
		end
	end

	// ==================================================
	// Half-period timebase
	logic [31:0] tick_cnt;
	logic [31:0] next_tick_cnt;
	logic phase;
	logic next_phase;
	logic half_tick;

	// Single timebase keeps both lamps in step
	always_comb
	begin
		half_tick = (tick_cnt == 32'(HALF_CYCLES - 1));
		next_tick_cnt = half_tick ? 32'h0 : tick_cnt + 32'h1;
		next_phase = half_tick ? ~phase : phase;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt <= 32'h0;
			phase <= 1'b0;
		end
		else
		begin
			tick_cnt <= next_tick_cnt;
			phase <= next_phase;
		end
	end

	// ==================================================
	// Power-cycle latches: reset is the only way out
	logic lat_proc;
	logic lat_temp;
	logic lat_flash_ok;
	logic lat_flash_fail;
	logic lat_cfg;
	logic next_lat_proc;
	logic next_lat_temp;
	logic next_lat_flash_ok;
	logic next_lat_flash_fail;
	logic next_lat_cfg;

	always_comb
	begin
		next_lat_proc = lat_proc | cond_s.proc_link_fail;
		next_lat_temp = lat_temp | cond_s.over_temp;
		next_lat_flash_ok = lat_flash_ok | cond_s.flash_ok;
		next_lat_flash_fail = lat_flash_fail | cond_s.flash_fail;
		next_lat_cfg = lat_cfg | cond_s.cfg_changed;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lat_proc <= 1'b0;
			lat_temp <= 1'b0;
			lat_flash_ok <= 1'b0;
			lat_flash_fail <= 1'b0;
			lat_cfg <= 1'b0;
		end
		else
		begin
			lat_proc <= next_lat_proc;
			lat_temp <= next_lat_temp;
			lat_flash_ok <= next_lat_flash_ok;
			lat_flash_fail <= next_lat_flash_fail;
			lat_cfg <= next_lat_cfg;
		end
	end

	// ==================================================
	// Encoder error blink: three red blinks after power-up
	logic [2:0] enc_left;
	logic [2:0] next_enc_left;
	logic enc_armed;
	logic next_enc_armed;
	logic [1:0] sync_fill;
	logic [1:0] next_sync_fill;

	// Only the first condition through the synchroniser counts as power-up;
	// looking earlier would see the synchroniser's reset zeros instead
	always_comb
	begin
		next_sync_fill = {sync_fill[0], 1'b1};
		next_enc_armed = enc_armed & (sync_fill != 2'h3);
		next_enc_left = enc_left;
		if (enc_armed && sync_fill == 2'h3 && cond_s.encoder_err)
			next_enc_left = 3'(ENC_BLINKS);
		else if (half_tick && phase && enc_left != 3'h0)
			next_enc_left = enc_left - 3'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enc_left <= 3'h0;
			enc_armed <= 1'b1;
			sync_fill <= 2'h0;
		end
		else
		begin
			enc_left <= next_enc_left;
			enc_armed <= next_enc_armed;
			sync_fill <= next_sync_fill;
		end
	end

	// ==================================================
	// TCP connection blink code: N blinks then a pause
	logic [3:0] grp_step;
	logic [3:0] next_grp_step;
	logic [2:0] tcp_n;
	logic [3:0] grp_len;

	always_comb
	begin
		tcp_n = (cond_s.tcp_count > 3'(MAX_TCP_BLINKS)) ? 3'(MAX_TCP_BLINKS) : cond_s.tcp_count;
		grp_len = 4'({tcp_n, 1'b0}) + 4'(GROUP_PAUSE_HALVES);
		next_grp_step = grp_step;
		if (half_tick)
			next_grp_step = (grp_step + 4'h1 >= grp_len) ? 4'h0 : grp_step + 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			grp_step <= 4'h0;
		else
			grp_step <= next_grp_step;
	end

	// ==================================================
	// Register bus: protocol select, latched status and interrupts
	logic [1:0] ctrl;
	logic [1:0] next_ctrl;
	logic [3:0] int_status;
	logic [3:0] next_int_status;
	logic [3:0] int_enable;
	logic [3:0] next_int_enable;
	logic [3:0] int_event;
	logic [4:0] status_word;
	logic [31:0] next_prdata;
	logic next_irq;
	logic access;
	logic addr_bad;
	logic wr_bad;
	logic wr_ok;

	// No wait states: every access phase completes at once
	assign pready = psel & penable;
	assign cmd_refused = lat_flash_ok;

	// Read data is taken in the setup cycle so it stands through the access phase.
	// An interrupt event outranks a clear in the same cycle, so no event is lost.
	always_comb
	begin
		access = psel & penable;
		addr_bad = (paddr != OFS_CTRL) && (paddr != OFS_STATUS) && (paddr != OFS_INT_STATUS)
			&& (paddr != OFS_INT_ENABLE) && (paddr != OFS_INT_CLEAR);
		wr_bad = (paddr == OFS_STATUS) || (paddr == OFS_INT_STATUS)
			|| (paddr == OFS_CTRL && pwdata[1:0] == 2'h3);
		pslverr = access && (addr_bad || (pwrite && (lat_flash_ok || wr_bad)));
		wr_ok = access && pwrite && !pslverr;
		status_word = 5'h0;
		status_word[INT_PROC_LINK] = lat_proc;
		status_word[INT_OVER_TEMP] = lat_temp;
		status_word[INT_FLASH_FAIL] = lat_flash_fail;
		status_word[INT_CFG_CHANGED] = lat_cfg;
		status_word[STATUS_FLASH_OK] = lat_flash_ok;
		int_event = 4'h0;
		int_event[INT_PROC_LINK] = next_lat_proc & ~lat_proc;
		int_event[INT_OVER_TEMP] = next_lat_temp & ~lat_temp;
		int_event[INT_FLASH_FAIL] = next_lat_flash_fail & ~lat_flash_fail;
		int_event[INT_CFG_CHANGED] = next_lat_cfg & ~lat_cfg;
		next_int_status = int_status;
		if (wr_ok && paddr == OFS_INT_CLEAR)
			next_int_status = int_status & ~pwdata[3:0];
		next_int_status = next_int_status | int_event;
		next_int_enable = (wr_ok && paddr == OFS_INT_ENABLE) ? pwdata[3:0] : int_enable;
		next_ctrl = (wr_ok && paddr == OFS_CTRL) ? pwdata[1:0] : ctrl;
		next_irq = |(int_status & int_enable);
		next_prdata = prdata;
		if (psel && !penable && !pwrite)
		begin
			case (paddr)
				OFS_CTRL: next_prdata = 32'(ctrl);
				OFS_STATUS: next_prdata = 32'(status_word);
				OFS_INT_STATUS: next_prdata = 32'(int_status);
				OFS_INT_ENABLE: next_prdata = 32'(int_enable);
				default: next_prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= CTRL_RESET;
			int_status <= 4'h0;
			int_enable <= INT_ENABLE_RESET;
			prdata <= 32'h0;
			irq <= 1'b0;
		end
		else
		begin
			ctrl <= next_ctrl;
			int_status <= next_int_status;
			int_enable <= next_int_enable;
			prdata <= next_prdata;
			irq <= next_irq;
		end
	end

	refused_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		access && pwrite && lat_flash_ok |-> pslverr)
		else $error("Write accepted after flash write");
	irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(int_status & int_enable)) |=> irq)
		else $error("Interrupt missing for enabled status");

	// ==================================================
	// Module health lamp priority
	slq_lamp_type next_mod;

	// Faults outrank initialisation, which outranks the operational states
	always_comb
	begin
		next_mod = '0;
		if (lat_temp)
			next_mod.red = 1'b1;
		else if (lat_proc)
		begin
			next_mod.red = phase;
			next_mod.green = ~phase;
		end
		else if (enc_left != 3'h0)
			next_mod.red = phase;
		else if (lat_cfg || lat_flash_fail)
			next_mod.red = phase;
		else if (lat_flash_ok)
			next_mod.green = 1'b1;
		else if (cond_s.self_test || cond_s.link_wait)
			next_mod.green = phase;
		else if (ctrl == PROTO_PNET)
			next_mod.green = cond_s.name_or_ip_set;
		else
			next_mod.green = cond_s.drive_ok & cond_s.net_ok;
	end

	// ==================================================
	// Network health lamp per protocol
	slq_lamp_type next_net;

	always_comb
	begin
		next_net = '0;
		if (lat_proc || cond_s.self_test)
		begin
			next_net.red = phase;
			next_net.green = ~phase;
		end
		else if (ctrl == PROTO_PNET)
		begin
			if (cond_s.dup_ip || cond_s.name_mismatch || !cond_s.ioc_conn)
				next_net = '0;
			else if (cond_s.ioc_run)
				next_net.green = 1'b1;
			else
				next_net.green = phase;
		end
		else if (cond_s.dup_ip)
			next_net.red = 1'b1;
		else if (ctrl == PROTO_MODBUS)
			next_net.green = phase && grp_step < 4'({tcp_n, 1'b0});
		// In protocol one a changed setting flashes both lamps, so the operator tells it from a flash failure
		else if (lat_cfg)
			next_net.red = phase;
		else if (cond_s.eth_link)
			next_net.green = cond_s.cip_open ? 1'b1 : phase;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			module_health_lamp <= '0;
			network_health_lamp <= '0;
		end
		else
		begin
			module_health_lamp <= next_mod;
			network_health_lamp <= next_net;
		end
	end

	// ==================================================
	// Lamp assertions and covers
	temp_red_a: assert property (@(posedge pclk) disable iff (!presetn)
		lat_temp |=> module_health_lamp.red && !module_health_lamp.green)
		else $error("Over-temperature lamp not steady red");
	proc_alternate_a: assert property (@(posedge pclk) disable iff (!presetn)
		lat_proc && !lat_temp |=> module_health_lamp.red != module_health_lamp.green)
		else $error("Link fault lamp not alternating");
	lamp_exclusive_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(module_health_lamp.red && module_health_lamp.green))
		else $error("Module lamp shows both colours");
	dup_red_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl != PROTO_PNET && cond_s.dup_ip && !lat_proc && !cond_s.self_test
		|=> network_health_lamp.red && !network_health_lamp.green)
		else $error("Duplicate address lamp not steady red");
	pnet_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl == PROTO_PNET && !lat_proc && !cond_s.self_test
		&& (cond_s.dup_ip || cond_s.name_mismatch || !cond_s.ioc_conn)
		|=> !network_health_lamp.red && !network_health_lamp.green)
		else $error("Network lamp lit without controller");
	enc_blink_c: cover property (@(posedge pclk) disable iff (!presetn)
		enc_left == 3'h1 && half_tick && phase);
	cfg_flash_c: cover property (@(posedge pclk) disable iff (!presetn)
		lat_cfg && network_health_lamp.red);
	tcp_wrap_c: cover property (@(posedge pclk) disable iff (!presetn)
		ctrl == PROTO_MODBUS && half_tick && tcp_n != 3'h0 && grp_step + 4'h1 >= grp_len);
	refuse_c: cover property (@(posedge pclk) disable iff (!presetn)
		access && pslverr && lat_flash_ok);
endmodule

// ===== testbench/slq_lamp_eye.sv
// Operator model: counts how long each colour of one lamp glows.
`timescale 1ns/1ps
module slq_lamp_eye
	import slq_pkg::*;
(
	input wire logic pclk,
	input wire logic clr,
	input wire slq_lamp_type lamp,
	output logic [15:0] red_cycles,
	output logic [15:0] green_cycles,
	output logic both_seen
);
	// ====
	// An eye only sees glow time, so counts restart on clr
	always_ff @(posedge pclk)
	begin
		red_cycles <= clr ? 16'h0 : red_cycles + 16'(lamp.red);
		green_cycles <= clr ? 16'h0 : green_cycles + 16'(lamp.green);
		both_seen <= clr ? 1'b0 : both_seen | (lamp.red & lamp.green);
	end
endmodule

// ===== testbench/test_status_lamp_sequencer.sv
// Testbench for the status lamp sequencer: lamp table, latched faults, interrupts.
`timescale 1ns/1ps
module test_status_lamp_sequencer
	import slq_pkg::*;
;
	// ====
	// Short half period keeps the run brief
	localparam int HALF = 4;
	localparam int WIN = 16 * HALF;
	typedef struct packed { logic [1:0] proto; logic [4:0] f; logic [2:0] ms; logic [2:0] ns; } slq_row_type;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic clr = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, cmd_refused, irq, mb, nb, e;
	logic [15:0] mr, mg, nr, ng;
	slq_lamp_type ml, nl;
	slq_cond_type cond = '{drive_ok: 1'b1, net_ok: 1'b1, eth_link: 1'b1, name_or_ip_set: 1'b1, default: '0};
	int errors = 0;
	int n_checks = 0;
	// Flags are {cip, dup, mismatch, ioc, run}; 7 skips the module lamp
	slq_row_type rows [9] = '{
		'{PROTO_ETHIP, 5'h00, 3'h1, 3'h2}, '{PROTO_ETHIP, 5'h08, 3'h7, 3'h3},
		'{PROTO_MODBUS, 5'h08, 3'h7, 3'h3}, '{PROTO_PNET, 5'h03, 3'h1, 3'h1},
		'{PROTO_PNET, 5'h02, 3'h7, 3'h2}, '{PROTO_PNET, 5'h06, 3'h7, 3'h0},
		'{PROTO_PNET, 5'h0b, 3'h7, 3'h0}, '{PROTO_PNET, 5'h00, 3'h7, 3'h0},
		'{PROTO_MODBUS, 5'h00, 3'h7, 3'h0}};
	always #12.5 pclk = ~pclk;
	slq_status_lamp_sequencer #(.HALF_CYCLES(HALF)) i_slq_status_lamp_sequencer (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cond(cond), .module_health_lamp(ml), .network_health_lamp(nl),
		.cmd_refused(cmd_refused), .irq(irq));
	slq_lamp_eye i_slq_lamp_eye_m (.pclk(pclk), .clr(clr), .lamp(ml), .red_cycles(mr), .green_cycles(mg),
		.both_seen(mb));
	slq_lamp_eye i_slq_lamp_eye_n (.pclk(pclk), .clr(clr), .lamp(nl), .red_cycles(nr), .green_cycles(ng),
		.both_seen(nb));
	// ====
	// Pattern class: 0 off, 1 green, 2 flash green, 3 red, 4 flash red, 5 both colours
	function automatic logic [2:0] seen(input logic [15:0] r, input logic [15:0] g);
		if (r == 0 && g == 0) return 3'h0;
		if (r == 0 && g == WIN) return 3'h1;
		if (r == 0) return 3'h2;
		if (g == 0 && r == WIN) return 3'h3;
		if (g == 0) return 3'h4;
		return 3'h5;
	endfunction
	task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		if (pready !== 1'b1)
			errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task power();
		@(posedge pclk);
		presetn <= 1'b0;
		clr <= 1'b1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		clr <= 1'b0;
	endtask
	// Settling cycles keep a late switch out of the window
	task look();
		repeat (4) @(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (WIN) @(posedge pclk);
		#1;
	endtask
	task end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ====
	initial
	begin
		#1000000;
		errors++;
		end_of_test();
	end
	initial
	begin
		power();
		apb(1'b0, OFS_CTRL, 0);
		chk("ctrl reset", q[1:0], CTRL_RESET);
		apb(1'b0, OFS_INT_ENABLE, 0);
		chk("enable reset", q[3:0], INT_ENABLE_RESET);
		foreach (rows[i])
		begin
			apb(1'b1, OFS_CTRL, 32'(rows[i].proto));
			@(posedge pclk);
			{cond.cip_open, cond.dup_ip, cond.name_mismatch, cond.ioc_conn, cond.ioc_run} <= rows[i].f;
			look();
			if (rows[i].ms != 3'h7) chk("module lamp", seen(mr, mg), rows[i].ms);
			chk("network lamp", seen(nr, ng), rows[i].ns);
		end
		$display("table done");
		// Two connections: a group is (2 * 2 blink halves + 4 pause halves) * HALF = 32 cycles, two groups per window
		apb(1'b1, OFS_CTRL, 32'(PROTO_MODBUS));
		cond.tcp_count <= 3'h2;
		look();
		chk("tcp green cycles", 32'(ng), 32'(2 * 2 * HALF));
		chk("tcp red cycles", 32'(nr), 32'h0);
		cond.tcp_count <= 3'h0;
		$display("tcp done");
		// Over-temperature outlives its cause; the interrupt clears apart
		apb(1'b1, OFS_INT_ENABLE, 32'h1 << INT_OVER_TEMP);
		@(posedge pclk);
		cond.over_temp <= 1'b1;
		repeat (4) @(posedge pclk);
		cond.over_temp <= 1'b0;
		look();
		chk("irq", irq, 1'b1);
		chk("module lamp", seen(mr, mg), 3'h3);
		apb(1'b0, OFS_INT_STATUS, 0);
		chk("over temp status", q[INT_OVER_TEMP], 1'b1);
		apb(1'b1, OFS_INT_CLEAR, 32'h1 << INT_OVER_TEMP);
		look();
		chk("irq", irq, 1'b0);
		chk("module lamp", seen(mr, mg), 3'h3);
		$display("over temp done");
		power();
		cond.proc_link_fail <= 1'b1;
		repeat (2) @(posedge pclk);
		cond.proc_link_fail <= 1'b0;
		look();
		chk("module lamp", seen(mr, mg), 3'h5);
		chk("both colours", mb, 1'b0);
		$display("link fault done");
		power();
		cond.link_wait <= 1'b1;
		look();
		chk("module lamp", seen(mr, mg), 3'h2);
		cond.link_wait <= 1'b0;
		cond.self_test <= 1'b1;
		look();
		chk("module lamp", seen(mr, mg), 3'h2);
		chk("network lamp", seen(nr, ng), 3'h5);
		chk("both colours", nb, 1'b0);
		cond.self_test <= 1'b0;
		$display("init done");
		// In protocol one a changed setting flashes both lamps red; its interrupt stays masked
		cond.cfg_changed <= 1'b1;
		repeat (2) @(posedge pclk);
		cond.cfg_changed <= 1'b0;
		look();
		chk("module lamp", seen(mr, mg), 3'h4);
		chk("network lamp", seen(nr, ng), 3'h4);
		apb(1'b0, OFS_INT_STATUS, 0);
		chk("cfg status", q[INT_CFG_CHANGED], 1'b1);
		chk("irq masked", irq, 1'b0);
		$display("config change done");
		power();
		cond.flash_fail <= 1'b1;
		repeat (2) @(posedge pclk);
		cond.flash_fail <= 1'b0;
		look();
		chk("module lamp", seen(mr, mg), 3'h4);
		chk("network lamp", seen(nr, ng), 3'h2);
		$display("flash fail done");
		power();
		cond.flash_ok <= 1'b1;
		repeat (2) @(posedge pclk);
		cond.flash_ok <= 1'b0;
		look();
		chk("refused", cmd_refused, 1'b1);
		chk("module lamp", seen(mr, mg), 3'h1);
		apb(1'b1, OFS_CTRL, 32'(PROTO_MODBUS));
		chk("write refused", e, 1'b1);
		apb(1'b0, OFS_CTRL, 0);
		chk("ctrl kept", q[1:0], CTRL_RESET);
		apb(1'b0, OFS_STATUS, 0);
		chk("flash ok status", q[STATUS_FLASH_OK], 1'b1);
		$display("flash done");
		cond.encoder_err <= 1'b1;
		power();
		repeat (WIN) @(posedge pclk);
		#1;
		chk("red cycles", 32'(mr), 32'(ENC_BLINKS * HALF));
		$display("encoder done");
		end_of_test();
	end
endmodule
